// ### rtl/sac_ctrl.sv
// sac_ctrl: read-out, conversion start and power control of an eight-channel
// simultaneous-sampling converter, with an apb port for samples and status.
// assumes the host drives the pins asynchronously and apb on pclk.
//
// Contract
// RULE_01: parallel mode drives bit 14 on its pin
// RULE_02: byte order pin picks upper or lower first
// RULE_03: host holds byte order pin low serially
// RULE_04: bits 13..9 driven only in parallel mode
// RULE_05: bit 8 parallel and serial, off in byte mode
// RULE_06: serial line b shifts channels five to eight
// RULE_07: bit 7 parallel, serial line a channels 1-4
// RULE_08: byte mode: two reads per result
// RULE_09: bits 6..0 driven in parallel mode
// RULE_10: standby low enters standby or shutdown
// RULE_11: power-down entry acts asynchronously
// RULE_12: standby keeps reference and regulator powered
// RULE_13: host waits after standby exit
// RULE_14: after shutdown a reset precedes conversion
// RULE_15: joined start edges sample all channels
// RULE_16: busy high at most the conversion time
// RULE_17: busy falls once results are stored
// RULE_18: read edges step channels from one
// RULE_19: every channel converted and read out
// RULE_20: first channel flag on first read
// RULE_21: strobes high end frame, outputs released
// RULE_22: interface pins select the read-out mode
// RULE_23: start edges ignored while busy
// RULE_24: chip select rise releases all outputs
// RULE_25: reset clears busy, pointer and pending start
// RULE_26: host avoids starts during power-down
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps

module sac_ctrl
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sac_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire sac_pkg::sac_pins_s pins_i,
  input wire logic [sac_pkg::BUS_W-1:0] bus_i,
  output logic [sac_pkg::BUS_W-1:0] bus_o,
  output logic [sac_pkg::BUS_W-1:0] bus_oe_n,
  output logic first_ch,
  output logic first_ch_oe_n,
  output logic busy,
  // power state
  output logic frontend_pwr_en,
  output logic reference_pwr_en
);
  import sac_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [PINS_W+1:0] sync_q;
  sac_pins_s ps;
  logic bm_s;
  logic bo_s;

  sac_sync #(.W(PINS_W+2), .RST(SYNC_RST)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(pce),
    .d({bus_i[MODE_BIT], bus_i[ORDER_BIT], pins_i}),
    .q(sync_q)
  );
  assign ps = sync_q[PINS_W-1:0];
  assign bm_s = sync_q[PINS_W+1];
  assign bo_s = sync_q[PINS_W];

  function automatic sac_mode_e mode_of(input logic if_sel, input logic bm);
    if (!if_sel)
      return MODE_PAR;
    else if (bm)
      return MODE_BYTE;
    else
      return MODE_SER;
  endfunction

  // hit flag on top, word index below
  function automatic logic [CH_W:0] win(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] base);
    return {(a[ADDR_W-1:5] == base[ADDR_W-1:5]) && (a[1:0] == 2'b00), a[4:2]};
  endfunction

  // ****************************************
  // power-down
  // ****************************************
  logic fe_pwr_r;
  logic ref_pwr_r;
  logic fe_clr_n;
  logic ref_clr_n;

  // raw pins clear at once; power returns only on a clock edge
  assign fe_clr_n = presetn & pins_i.standby_n; // RULE_10 RULE_11
  assign ref_clr_n = presetn & (pins_i.standby_n | pins_i.range_sel); // RULE_12

  always_ff @(posedge pclk or negedge fe_clr_n)
  begin
    if (!fe_clr_n)
      fe_pwr_r <= 1'b0;
    else if (pce)
      fe_pwr_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge ref_clr_n)
  begin
    if (!ref_clr_n)
      ref_pwr_r <= 1'b0;
    else if (pce)
      ref_pwr_r <= 1'b1;
  end

  // ****************************************
  // conversion
  // ****************************************
  sac_conv_e st_r, st_nxt;
  logic [CONV_CNT_W-1:0] cnt_r, cnt_nxt;
  logic seen_a_r, seen_a_nxt, seen_b_r, seen_b_nxt, ca_q, cb_q;
  logic nrst_r, nrst_nxt, busy_r, busy_nxt, done, srst;
  logic [RES_W-1:0] samp_r [CHANNELS];
  logic [RES_W-1:0] samp_nxt [CHANNELS];
  logic [RES_W-1:0] hold_r [CHANNELS];
  logic [RES_W-1:0] hold_nxt [CHANNELS];
  logic [RES_W-1:0] res_r [CHANNELS];
  logic [RES_W-1:0] res_nxt [CHANNELS];

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    seen_a_nxt = seen_a_r | (ps.conv_a & ~ca_q);
    seen_b_nxt = seen_b_r | (ps.conv_b & ~cb_q);
    hold_nxt = hold_r;
    res_nxt = res_r;
    done = 1'b0;
    // a shutdown level seen at any edge wins over the clearing reset
    nrst_nxt = (~ps.standby_n & ~ps.range_sel) | (nrst_r & ~srst); // RULE_14
    case (st_r)
      CS_IDLE:
      begin
        if (!fe_pwr_r || nrst_r)
        begin
          seen_a_nxt = 1'b0;
          seen_b_nxt = 1'b0;
        end
        else if (seen_a_nxt && seen_b_nxt) // RULE_15
        begin
          st_nxt = CS_CONV;
          cnt_nxt = CONV_CNT - CONV_CNT_W'(1);
          hold_nxt = samp_r;
          seen_a_nxt = 1'b0;
          seen_b_nxt = 1'b0;
        end
      end
      CS_CONV:
      begin
        seen_a_nxt = 1'b0; // RULE_23
        seen_b_nxt = 1'b0; // RULE_23
        // dropping power aborts and keeps the previous results
        if (!fe_pwr_r)
          st_nxt = CS_IDLE;
        else if (cnt_r == '0)
        begin
          st_nxt = CS_IDLE;
          res_nxt = hold_r; // RULE_17 RULE_19
          done = 1'b1;
        end
        else
          cnt_nxt = cnt_r - CONV_CNT_W'(1);
      end
      default: st_nxt = CS_IDLE;
    endcase
    if (srst)
    begin
      st_nxt = CS_IDLE;
      seen_a_nxt = 1'b0;
      seen_b_nxt = 1'b0;
    end
    busy_nxt = (st_nxt == CS_CONV); // RULE_16
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= CS_IDLE; // RULE_25
      cnt_r <= '0;
      seen_a_r <= 1'b0;
      seen_b_r <= 1'b0;
      ca_q <= 1'b0;
      cb_q <= 1'b0;
      nrst_r <= 1'b0;
      busy_r <= 1'b0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        hold_r[i] <= RES_RST;
        res_r[i] <= RES_RST;
      end
    end
    else if (pce)
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      seen_a_r <= seen_a_nxt;
      seen_b_r <= seen_b_nxt;
      ca_q <= ps.conv_a;
      cb_q <= ps.conv_b;
      nrst_r <= nrst_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      res_r <= res_nxt;
    end
  end

  // ****************************************
  // read-out frame
  // ****************************************
  sac_mode_e mode_r, mode_nxt;
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  logic [SER_W-1:0] ser_r, ser_nxt;
  logic [BUS_W-1:0] bus_o_r, bus_o_nxt, oe_r, oe_nxt;
  logic flag_r, flag_nxt, foe_r, foe_nxt;
  logic strb_q, cs_q, rd_q, strb_n, fall, cs_rise, cs_fall, sclk_rise, upper;
  logic [RES_W-1:0] word;
  logic [CH_W-1:0] rch;

  assign strb_n = ps.cs_n | ps.rd_n;
  assign fall = strb_q & ~strb_n;
  assign cs_rise = ps.cs_n & ~cs_q;
  assign cs_fall = ~ps.cs_n & cs_q;
  assign sclk_rise = ps.rd_n & ~rd_q & ~ps.cs_n;

  always_comb
  begin
    mode_nxt = mode_of(ps.if_sel, bm_s); // RULE_22
    ptr_nxt = ptr_r;
    ser_nxt = ser_r;
    bus_o_nxt = bus_o_r;
    oe_nxt = oe_r;
    flag_nxt = flag_r;
    foe_nxt = foe_r;
    rch = (mode_r == MODE_BYTE) ? ptr_r[PTR_W-1:1] : ptr_r[CH_W-1:0];
    word = res_r[rch];
    upper = ptr_r[0] ^ bo_s; // RULE_02
    if (cs_fall)
    begin
      foe_nxt = 1'b0;
      flag_nxt = 1'b0;
    end
    case (mode_r)
      MODE_PAR:
      begin
        if (fall)
        begin
          bus_o_nxt = word; // RULE_01 RULE_04 RULE_05 RULE_07 RULE_09
          oe_nxt = OE_ALL_ON;
          flag_nxt = (ptr_r == '0); // RULE_20
          ptr_nxt = ptr_r + PTR_W'(1); // RULE_18 RULE_19
        end
        else if (strb_n)
          oe_nxt = OE_ALL_OFF;
      end
      MODE_BYTE:
      begin
        if (fall)
        begin
          // upper pins stay released: bits 15 and 14 are inputs here
          bus_o_nxt = {8'h00, upper ? word[15:8] : word[7:0]}; // RULE_08
          oe_nxt = OE_BYTE; // RULE_05
          flag_nxt = (ptr_r[PTR_W-1:1] == '0); // RULE_20
          ptr_nxt = ptr_r + PTR_W'(1); // RULE_18
        end
        else if (strb_n)
          oe_nxt = OE_ALL_OFF;
      end
      default:
      begin
        if (cs_fall)
          ser_nxt = '0;
        else if (sclk_rise)
          ser_nxt = ser_r + SER_W'(1);
        if (cs_fall || sclk_rise)
        begin
          bus_o_nxt = '0;
          bus_o_nxt[SER_A_BIT] = res_r[{1'b0, ser_nxt[5:4]}][~ser_nxt[3:0]]; // RULE_07
          bus_o_nxt[SER_B_BIT] = res_r[{1'b1, ser_nxt[5:4]}][~ser_nxt[3:0]]; // RULE_06
          oe_nxt = OE_SER;
          flag_nxt = (ser_nxt < SER_FIRST_END);
        end
      end
    endcase
    if (cs_rise || srst)
    begin
      oe_nxt = OE_ALL_OFF; // RULE_21 RULE_24
      foe_nxt = 1'b1; // RULE_21
    end
    if (done || srst)
    begin
      ptr_nxt = '0; // RULE_18 RULE_25
      ser_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= MODE_PAR;
      ptr_r <= '0; // RULE_25
      ser_r <= '0;
      bus_o_r <= '0;
      oe_r <= OE_ALL_OFF; // RULE_25
      flag_r <= 1'b0;
      foe_r <= 1'b1;
      strb_q <= 1'b1;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
    end
    else if (pce)
    begin
      mode_r <= mode_nxt;
      ptr_r <= ptr_nxt;
      ser_r <= ser_nxt;
      bus_o_r <= bus_o_nxt;
      oe_r <= oe_nxt;
      flag_r <= flag_nxt;
      foe_r <= foe_nxt;
      strb_q <= strb_n;
      cs_q <= ps.cs_n;
      rd_q <= ps.rd_n;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic rdy_r, rdy_nxt, err_r, err_nxt, setup, acc;
  logic [31:0] rdata_r, rdata_nxt;
  logic [CH_W:0] w_s, w_r;

  // answer one cycle after setup: no wait states beyond the access phase
  assign setup = psel & ~penable & ~rdy_r;
  assign acc = psel & penable & rdy_r;
  assign w_s = win(paddr, SAMP_BASE);
  assign w_r = win(paddr, RES_BASE);
  assign srst = acc & pwrite & (paddr == CTRL_OFF) & pwdata[CTRL_SRST_BIT]; // RULE_14

  always_comb
  begin
    rdy_nxt = setup;
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    samp_nxt = samp_r;
    if (setup)
    begin
      rdata_nxt = '0;
      err_nxt = 1'b0;
      if (paddr == CTRL_OFF)
        rdata_nxt = '0;
      else if (paddr == STAT_OFF)
      begin
        rdata_nxt[STAT_BUSY_BIT] = busy_r;
        rdata_nxt[STAT_MODE_LSB +: 3] = mode_r;
        rdata_nxt[STAT_PTR_LSB +: PTR_W] = ptr_r;
        rdata_nxt[STAT_FE_BIT] = fe_pwr_r;
        rdata_nxt[STAT_REF_BIT] = ref_pwr_r;
        rdata_nxt[STAT_NRST_BIT] = nrst_r;
      end
      else if (w_s[CH_W])
        rdata_nxt[RES_W-1:0] = samp_r[w_s[CH_W-1:0]];
      else if (w_r[CH_W])
        rdata_nxt[RES_W-1:0] = res_r[w_r[CH_W-1:0]];
      else
        err_nxt = 1'b1;
    end
    if (acc && pwrite && w_s[CH_W])
      samp_nxt[w_s[CH_W-1:0]] = pwdata[RES_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= '0;
      for (int i = 0; i < CHANNELS; i++)
        samp_r[i] <= RES_RST;
    end
    else if (pce)
    begin
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
      samp_r <= samp_nxt;
    end
  end

  assign prdata = rdata_r;
  assign pready = rdy_r;
  assign pslverr = err_r;
  assign bus_o = bus_o_r;
  assign bus_oe_n = oe_r;
  assign first_ch = flag_r;
  assign first_ch_oe_n = foe_r;
  assign busy = busy_r;
  assign frontend_pwr_en = fe_pwr_r;
  assign reference_pwr_en = ref_pwr_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [CONV_CNT_W:0] blen_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blen_r <= '0;
    else if (pce)
      blen_r <= busy_r ? blen_r + (CONV_CNT_W+1)'(1) : '0;
  end

  AST_BUSY_MAX: assert property (blen_r <= {1'b0, CONV_CNT}) // RULE_16
    else $error("busy held longer than the conversion time");
  AST_START_IGNORED: assert property (pce && busy_r |=> !seen_a_r && !seen_b_r) // RULE_23
    else $error("start edge recorded while busy");
  AST_PTR_REWIND: assert property (pce && done |=> ptr_r == '0 && !busy_r) // RULE_18
    else $error("read pointer not rewound at end of conversion");
  // soft reset aborts like power-down and keeps the old results, unless it lands in the last conversion cycle, which still stores them
  AST_RES_STORED: assert property ($fell(busy_r) && $past(fe_pwr_r) && !$past(srst)
      |-> res_r[0] == hold_r[0] && res_r[7] == hold_r[7]) // RULE_17
    else $error("busy fell before results were stored");
  AST_PAR_DRIVE: assert property (pce && fall && mode_r == MODE_PAR && !cs_rise && !srst
      |=> bus_oe_n == OE_ALL_ON && bus_o == $past(word)) // RULE_01
    else $error("parallel read did not drive the result");
  AST_BYTE_HIGH_OFF: assert property (pce && fall && mode_r == MODE_BYTE
      |=> bus_oe_n[15:8] == 8'hff) // RULE_05
    else $error("upper pins driven in byte mode");
  AST_CS_RELEASE: assert property (pce && cs_rise |=> bus_oe_n == OE_ALL_OFF && first_ch_oe_n) // RULE_24
    else $error("outputs still driven after chip select rise");
  AST_FLAG_FIRST: assert property (pce && fall && mode_r == MODE_PAR && !cs_rise && !srst
      |=> first_ch == ($past(ptr_r) == '0)) // RULE_20
    else $error("first channel flag wrong");
  AST_SHUTDOWN: assert property (!pins_i.standby_n && !pins_i.range_sel
      |-> !reference_pwr_en && !frontend_pwr_en) // RULE_10
    else $error("shutdown did not power down");
  AST_APB_READY: assert property (pce && setup |=> pready ##1 !pready || !pce)
    else $error("apb answer not one cycle after setup");

  COV_CONV_DONE: cover property ($fell(busy_r));
  COV_BYTE_READ: cover property (fall && mode_r == MODE_BYTE && ptr_r == 4'h1);
  COV_SER_FRAME: cover property (cs_fall && mode_r == MODE_SER);

endmodule // sac_ctrl

// ### rtl/sac_pkg.sv
// sac_pkg: shared constants and types of the sampling converter control block.
// assumes a 50 MHz pclk; all host pins are asynchronous to it.

package sac_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  // plain default, the analog core itself is not part of this block
  localparam int unsigned CONV_TIME_NS = 4000;
  // longest time, so the count rounds down
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT = CONV_CNT_W'(CONV_CYCLES);

  // ****************************************
  // geometry
  // ****************************************
  localparam int CHANNELS = 8;
  localparam int CH_W = 3;
  localparam int RES_W = 16;
  localparam int BUS_W = 16;
  localparam int PTR_W = 4;
  localparam int SER_W = 6;
  localparam logic [SER_W-1:0] SER_FIRST_END = 6'h10;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;

  // ****************************************
  // shared bus pin positions and enables
  // ****************************************
  localparam int ORDER_BIT = 14;
  localparam int MODE_BIT = 15;
  localparam int SER_A_BIT = 7;
  localparam int SER_B_BIT = 8;
  localparam logic [BUS_W-1:0] OE_ALL_OFF = 16'hffff;
  localparam logic [BUS_W-1:0] OE_ALL_ON = 16'h0000;
  localparam logic [BUS_W-1:0] OE_BYTE = 16'hff00;
  localparam logic [BUS_W-1:0] OE_SER = 16'hfe7f;

  // ****************************************
  // apb register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFF = 12'h004;
  localparam logic [ADDR_W-1:0] SAMP_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] RES_BASE = 12'h040;
  localparam int CTRL_SRST_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int STAT_PTR_LSB = 4;
  localparam int STAT_FE_BIT = 8;
  localparam int STAT_REF_BIT = 9;
  localparam int STAT_NRST_BIT = 10;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_PAR = 3'b001,
    MODE_BYTE = 3'b010,
    MODE_SER = 3'b100
  } sac_mode_e;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_CONV = 2'b10
  } sac_conv_e;

  typedef struct packed {
    logic conv_a;
    logic conv_b;
    logic cs_n;
    logic rd_n;
    logic standby_n;
    logic range_sel;
    logic if_sel;
  } sac_pins_s;

  localparam int PINS_W = $bits(sac_pins_s);
  // order {byte_mode, byte_order, pins}: strobes and standby idle high
  localparam logic [PINS_W+1:0] SYNC_RST = 9'h01c;

endpackage

// ### rtl/sac_sync.sv
// sac_sync: two-stage synchroniser for a vector of asynchronous pins.
// assumes the bits are independent levels; no bus coherence is given.
`timescale 1ns/10ps

module sac_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // first stage feeds the second stage only
  always_comb
  begin
    meta_nxt = ce ? d : meta_r;
    q_nxt = ce ? meta_r : q_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RST;
      q_r <= RST;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule // sac_sync

// ### verif/sac_host.sv
// sac_host: host side of the converter pins, driving starts, strobes and modes.
// assumes pclk from the bench; every pin moves just after a rising edge.
`timescale 1ns/10ps

module sac_host
(
  // clock
  input wire logic pclk,
  // device side
  input wire logic [sac_pkg::BUS_W-1:0] bus_o,
  input wire logic [sac_pkg::BUS_W-1:0] bus_oe_n,
  output sac_pkg::sac_pins_s pins,
  output logic [sac_pkg::BUS_W-1:0] bus_i
);
  import sac_pkg::*;
  logic bm;
  logic bo;
  logic tog;
  logic [BUS_W-1:0] hen;
  // ****************************************
  // pin levels
  // ****************************************
  initial
  begin
    pins = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    bm = 1'b0;
    bo = 1'b0;
    tog = 1'b0;
  end
  always @(posedge pclk) tog <= ~tog;
  // unused lines held low outside parallel mode; bit 8 stays floating in byte mode
  assign hen = !pins.if_sel ? 16'h0000 : (bm ? 16'hfe00 : 16'hfe7f);
  // floating lines wobble so a stale value never looks driven
  always_comb
    for (int i = 0; i < BUS_W; i++)
      bus_i[i] = !bus_oe_n[i] ? bus_o[i] : hen[i] ? (i == 15 ? bm : i == 14 ? bo : 1'b0)
        : tog ^ i[0];
  // ****************************************
  // host actions
  // ****************************************
  task automatic cv(input logic v);
    @(posedge pclk);
    pins.conv_a <= v;
    pins.conv_b <= v;
  endtask
  task automatic strobe(input logic cs, input logic rd);
    @(posedge pclk);
    pins.cs_n <= cs;
    pins.rd_n <= rd;
  endtask
  task automatic sb(input logic s, input logic r);
    @(posedge pclk);
    pins.standby_n <= s;
    pins.range_sel <= r;
  endtask
  task automatic md(input logic ifs, input logic b, input logic o);
    @(posedge pclk);
    pins.if_sel <= ifs;
    bm <= b;
    bo <= o & b;
  endtask
endmodule // sac_host

// ### verif/tb.sv
// tb: self-checking bench of the converter control block.
// assumes sac_ctrl with apb on pclk and the host pin model sac_host.
`timescale 1ns/10ps

module tb;
  import sac_pkg::*;
  // 100 us at 20 ns; shutdown settling shortened too, the device does not time it
  localparam int WAKE = 5000;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, sa, sb;
  sac_pins_s pins;
  logic [BUS_W-1:0] bus_i, bus_o, bus_oe_n;
  logic first_ch, first_ch_oe_n, busy, fe_en, ref_en;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  logic [15:0] smp [8] = '{16'ha5c3, 16'h1234, 16'hfe01, 16'h7f80, 16'h0ff0, 16'hc35a,
    16'h8001, 16'h4bd2};
  sac_ctrl i_dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_i(pins), .bus_i(bus_i), .bus_o(bus_o), .bus_oe_n(bus_oe_n),
    .first_ch(first_ch), .first_ch_oe_n(first_ch_oe_n), .busy(busy),
    .frontend_pwr_en(fe_en), .reference_pwr_en(ref_en));
  sac_host i_host (.pclk(pclk), .bus_o(bus_o), .bus_oe_n(bus_oe_n), .pins(pins), .bus_i(bus_i));
  // ****************************************
  // helpers
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report;
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are taken at the rising edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pins pass two sync stages and an edge detect before they act
  task automatic settle;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic conv(input logic hit);
    i_host.cv(1'b1);
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
      @(negedge pclk);
      n++;
    end
    chk("busy start", busy, hit);
    n = 0;
    // start pins keep toggling while busy; none may restart or queue
    while (busy === 1'b1 && n < 300)
    begin
      i_host.cv(n[4]);
      @(negedge pclk);
      n++;
    end
    if (hit)
      chk("busy cycles", 16'(n), 16'(CONV_CNT));
    i_host.cv(1'b0);
    settle();
    chk("busy after", busy, 1'b0);
  endtask
  task automatic rd_one(input logic [15:0] exp, input logic [15:0] msk, input logic f);
    i_host.strobe(1'b0, 1'b0);
    settle();
    chk("data", bus_o & msk, exp);
    chk("oe", bus_oe_n, ~msk);
    chk("first", first_ch, f);
    i_host.strobe(1'b1, 1'b1);
    settle();
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    chk("rst busy", busy, 1'b0);
    chk("rst oe", bus_oe_n, OE_ALL_OFF);
    chk("rst flag oe", first_ch_oe_n, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    settle();
    for (int k = 0; k < CHANNELS; k++)
      apb(1'b1, SAMP_BASE + ADDR_W'(4 * k), {16'h0000, smp[k]});
    apb(1'b1, 12'h100, 32'h0000_0000);
    chk("unmapped", err, 1'b1);
    conv(1'b1);
    for (int k = 0; k < CHANNELS; k++)
    begin
      apb(1'b0, RES_BASE + ADDR_W'(4 * k), 32'h0000_0000);
      chk("result", rd[15:0], smp[k]);
    end
    for (int k = 0; k < CHANNELS; k++)
      rd_one(smp[k], 16'hffff, k == 0);
    chk("par release", bus_oe_n, OE_ALL_OFF);
    chk("flag release", first_ch_oe_n, 1'b1);
    i_host.md(1'b1, 1'b1, 1'b1);
    conv(1'b1);
    rd_one({8'h00, smp[0][15:8]}, 16'h00ff, 1'b1);
    rd_one({8'h00, smp[0][7:0]}, 16'h00ff, 1'b1);
    i_host.md(1'b1, 1'b1, 1'b0);
    rd_one({8'h00, smp[1][7:0]}, 16'h00ff, 1'b0);
    rd_one({8'h00, smp[1][15:8]}, 16'h00ff, 1'b0);
    i_host.md(1'b1, 1'b0, 1'b0);
    conv(1'b1);
    sa = {smp[0], smp[1]};
    sb = {smp[4], smp[5]};
    i_host.strobe(1'b0, 1'b1);
    settle();
    chk("ser oe", bus_oe_n, OE_SER);
    for (int j = 0; j <= 16; j++)
    begin
      chk("ser a", bus_o[SER_A_BIT], sa[31 - j]);
      chk("ser b", bus_o[SER_B_BIT], sb[31 - j]);
      chk("ser first", first_ch, j < 16);
      i_host.strobe(1'b0, 1'b0);
      settle();
      i_host.strobe(1'b0, 1'b1);
      settle();
    end
    i_host.strobe(1'b1, 1'b1);
    settle();
    chk("ser release", bus_oe_n, OE_ALL_OFF);
    i_host.sb(1'b0, 1'b1);
    @(negedge pclk);
    chk("standby_n front", fe_en, 1'b0);
    chk("standby_n ref", ref_en, 1'b1);
    i_host.sb(1'b1, 1'b1);
    repeat (WAKE) @(posedge pclk);
    settle();
    chk("wake front", fe_en, 1'b1);
    i_host.sb(1'b0, 1'b0);
    @(negedge pclk);
    chk("shdn ref", ref_en, 1'b0);
    chk("shdn front", fe_en, 1'b0);
    i_host.sb(1'b1, 1'b1);
    repeat (WAKE) @(posedge pclk);
    conv(1'b0);
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    settle();
    conv(1'b1);
    final_report();
  end
endmodule // tb
